// *** inc/xdcr_regs_pkg.sv ***
package xdcr_regs_pkg;

  // =====================================================================
  // Register offsets, as register numbers carried in the pointer byte.
  // =====================================================================
  localparam logic [7:0] REG_PRESS_VOLT = 8'h06; // Pressure element voltage.
  localparam logic [7:0] REG_TEMP_VOLT = 8'h07; // Temperature element voltage.
  localparam logic [7:0] REG_BUS_ADDR = 8'h42; // Bus device address.
  localparam logic [7:0] REG_FIT = 8'h43; // Coefficient fit orders.

  // =====================================================================
  // Bus address values.
  // =====================================================================
  localparam logic [7:0] ADDR_MIN = 8'h01; // Lowest valid address.
  localparam logic [7:0] ADDR_MAX = 8'h7F; // Highest valid address.
  localparam logic [6:0] ADDR_DEFAULT = 7'h02; // Fallback address.
  localparam logic [31:0] ADDR_WORD_DEFAULT = 32'h0000_0002; // Reset word.

  // =====================================================================
  // Transfer framing: byte 0 is the address, byte 1 the register
  // pointer, bytes 2 to 5 the data word, most significant byte first.
  // =====================================================================
  localparam logic [2:0] BYTE_ADDR = 3'h0; // Address byte index.
  localparam logic [2:0] BYTE_PTR = 3'h1; // Pointer byte index.
  localparam logic [2:0] BYTE_LAST = 3'h5; // Last data byte index.
  localparam logic [2:0] BYTE_CAP = 3'h6; // Saturation of the byte count.
  localparam logic [2:0] BIT_LAST = 3'h7; // Last bit of a byte.

  // The four fit orders, packed in register bit order.
  typedef struct packed {
    logic [7:0] tt; // Temperature-related temperature order.
    logic [7:0] tp; // Pressure-related temperature order.
    logic [7:0] pt; // Temperature-related pressure order.
    logic [7:0] pp; // Pressure-related pressure order.
  } fit_orders_type;

  // The two sensing-element voltages, as float bit patterns.
  typedef struct packed {
    logic [31:0] press; // Pressure element voltage.
    logic [31:0] temp; // Temperature element voltage.
  } element_volts_type;

  // Serial engine states, one-hot.
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, // Not addressed.
    ST_RX = 7'h02, // Shifting a byte in.
    ST_ACK = 7'h04, // Waiting to drive the acknowledge.
    ST_ACKH = 7'h08, // Holding the acknowledge low.
    ST_TX = 7'h10, // Shifting a byte out.
    ST_RACK = 7'h20, // Sampling the master's acknowledge.
    ST_RNEXT = 7'h40 // Driving the first bit of the next byte.
  } link_state_type;

endpackage

// *** logic/xdcr_regs.sv ***
`timescale 1ns/100ps

module xdcr_regs
  import xdcr_regs_pkg::*;
#(
  parameter logic [7:0] TT_ORDER = 8'h03,
  parameter logic [7:0] TP_ORDER = 8'h03,
  parameter logic [7:0] PT_ORDER = 8'h03,
  parameter logic [7:0] PP_ORDER = 8'h03
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire element_volts_type i_volts,
  input wire logic i_volt_update,
  input wire logic i_auto_update,
  input wire logic i_status_reset,
  input wire logic [31:0] i_nvm_addr_word,
  output logic o_conversion_done_flag_clear,
  output element_volts_type o_volts,
  output logic [31:0] o_addr_word,
  output logic [6:0] o_active_addr
);

  // =====================================================================
  // Pin synchronisers and line event detection.
  // =====================================================================
  logic scl_m_r, scl_s_r, scl_d_r; // SCL meta, synced and delayed stages.
  logic sda_m_r, sda_s_r, sda_d_r; // SDA meta, synced and delayed stages.

  // Two flops per pin, then one more stage for edge finding.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
      {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
    end else if (i_ce) begin
      {scl_m_r, scl_s_r, scl_d_r} <= {i_scl, scl_m_r, scl_s_r};
      {sda_m_r, sda_s_r, sda_d_r} <= {i_sda, sda_m_r, sda_s_r};
    end
  end

  wire scl_rise = scl_s_r & ~scl_d_r; // Clock rising: sample data.
  wire scl_fall = ~scl_s_r & scl_d_r; // Clock falling: change data.
  wire bus_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r; // Start.
  wire bus_stop = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r; // Stop.

  // =====================================================================
  // Register storage.
  // =====================================================================
  element_volts_type volts_r; // Latest element voltages.
  logic [31:0] addr_word_r; // Bus address register, all 32 bits kept.
  logic [6:0] active_addr_r; // Address the engine answers to.
  logic reload_r; // Pending load of the stored address after reset.
  fit_orders_type fit_orders; // Constant fit orders.

  assign fit_orders = '{tt: TT_ORDER, tp: TP_ORDER, pt: PT_ORDER,
                        pp: PP_ORDER};

  // =====================================================================
  // Serial engine state.
  // =====================================================================
  link_state_type state_r; // Engine state.
  logic [2:0] bit_cnt_r; // Bits done in the current byte.
  logic [2:0] byte_cnt_r; // Bytes done in the current transfer.
  logic [6:0] shift_r; // Bits received so far.
  logic rd_r; // Transfer is a read.
  logic [7:0] ptr_r; // Register pointer.
  logic [23:0] wdata_r; // Upper three bytes of the write word.
  logic [31:0] tx_r; // Outgoing word.

  wire [7:0] rx_byte = {shift_r, sda_s_r}; // Byte completed this edge.
  wire byte_done = (state_r == ST_RX) & scl_rise & (bit_cnt_r == BIT_LAST);
  wire addr_hit = (rx_byte[7:1] == active_addr_r); // Address match.
  wire commit = byte_done & (byte_cnt_r == BYTE_LAST); // Word complete.
  wire [31:0] commit_word = {wdata_r, rx_byte}; // Word being written.
  wire addr_wr = commit & (ptr_r == REG_BUS_ADDR);
  wire ptr_volt = (ptr_r == REG_PRESS_VOLT) | (ptr_r == REG_TEMP_VOLT);
  wire rd_start = (state_r == ST_ACKH) & scl_fall & rd_r &
                  (byte_cnt_r == BYTE_PTR); // Only the read address done.

  // Read selection; unknown pointers read as zero.
  wire sel_press = (ptr_r == REG_PRESS_VOLT);
  wire sel_temp = (ptr_r == REG_TEMP_VOLT);
  wire sel_addr = (ptr_r == REG_BUS_ADDR);
  wire sel_fit = (ptr_r == REG_FIT);
  wire [31:0] rd_word = sel_press ? volts_r.press :
                        sel_temp ? volts_r.temp :
                        sel_addr ? addr_word_r :
                        sel_fit ? fit_orders : 32'h0000_0000;

  // Validity of an address byte held in the low byte of a word.
  wire [7:0] nvm_byte = i_nvm_addr_word[7:0];
  wire nvm_valid = (nvm_byte >= ADDR_MIN) & (nvm_byte <= ADDR_MAX);

  // =====================================================================
  // Voltages: latched when the conversion logic updates them.
  // =====================================================================
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      volts_r <= '0;
    end else if (i_ce && i_volt_update) begin
      volts_r <= i_volts;
    end
  end

  // =====================================================================
  // Address register and active address. The active address is only
  // reloaded after a reset, so a written value waits for the save and
  // the restart.
  // =====================================================================
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      reload_r <= 1'b1;
      addr_word_r <= ADDR_WORD_DEFAULT;
      active_addr_r <= ADDR_DEFAULT;
    end else if (i_ce) begin
      if (i_status_reset) begin
        // A reset through the status register restarts the load.
        reload_r <= 1'b1;
      end else if (reload_r) begin
        // Load the stored word; an invalid address falls back to 2.
        reload_r <= 1'b0;
        addr_word_r <= i_nvm_addr_word;
        active_addr_r <= nvm_valid ? nvm_byte[6:0] : ADDR_DEFAULT;
      end else if (addr_wr) begin
        // A write changes the register only, not the live address.
        addr_word_r <= commit_word;
      end
    end
  end

  // =====================================================================
  // Serial engine.
  // =====================================================================
  always_ff @(posedge i_mclk) begin
    if (i_srst || (i_ce && i_status_reset)) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 3'h0;
      shift_r <= 7'h00;
      rd_r <= 1'b0;
      ptr_r <= 8'h00;
      wdata_r <= 24'h000000;
      tx_r <= 32'h0000_0000;
      o_sda_oe <= 1'b0;
      o_conversion_done_flag_clear <= 1'b0;
    end else if (i_ce) begin
      o_conversion_done_flag_clear <= 1'b0;
      if (bus_start) begin
        // A start or repeated start always opens a new address byte.
        state_r <= ST_RX;
        bit_cnt_r <= 3'h0;
        byte_cnt_r <= BYTE_ADDR;
        o_sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state_r <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        unique case (state_r)
          ST_IDLE: begin
            o_sda_oe <= 1'b0;
          end
          ST_RX: begin
            if (scl_rise) begin
              shift_r <= rx_byte[6:0];
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (bit_cnt_r == BIT_LAST) begin
                if (byte_cnt_r != BYTE_CAP) begin
                  byte_cnt_r <= byte_cnt_r + 3'h1;
                end
                if (byte_cnt_r == BYTE_ADDR) begin
                  // Answer only to the live address.
                  rd_r <= rx_byte[0];
                  state_r <= addr_hit ? ST_ACK : ST_IDLE;
                end else begin
                  state_r <= ST_ACK;
                  if (byte_cnt_r == BYTE_PTR) begin
                    ptr_r <= rx_byte;
                  end else begin
                    wdata_r <= {wdata_r[15:0], rx_byte};
                  end
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              o_sda_oe <= 1'b1;
              state_r <= ST_ACKH;
            end
          end
          ST_ACKH: begin
            if (scl_fall) begin
              if (rd_start) begin
                // Capture the word once so it cannot tear mid-read.
                o_sda_oe <= ~rd_word[31];
                tx_r <= {rd_word[30:0], 1'b0};
                bit_cnt_r <= 3'h0;
                state_r <= ST_TX;
                o_conversion_done_flag_clear <= ptr_volt & i_auto_update;
              end else begin
                o_sda_oe <= 1'b0;
                state_r <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_cnt_r <= bit_cnt_r + 3'h1;
            end else if (scl_fall) begin
              if (bit_cnt_r == 3'h0) begin
                o_sda_oe <= 1'b0;
                state_r <= ST_RACK;
              end else begin
                o_sda_oe <= ~tx_r[31];
                tx_r <= {tx_r[30:0], 1'b0};
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              state_r <= sda_s_r ? ST_IDLE : ST_RNEXT;
            end
          end
          ST_RNEXT: begin
            if (scl_fall) begin
              o_sda_oe <= ~tx_r[31];
              tx_r <= {tx_r[30:0], 1'b0};
              state_r <= ST_TX;
            end
          end
          default: begin
            state_r <= ST_IDLE;
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // =====================================================================
  // Output registers.
  // =====================================================================
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_sda_o <= 1'b0;
      o_volts <= '0;
      o_addr_word <= ADDR_WORD_DEFAULT;
      o_active_addr <= ADDR_DEFAULT;
    end else if (i_ce) begin
      o_sda_o <= 1'b0;
      o_volts <= volts_r;
      o_addr_word <= addr_word_r;
      o_active_addr <= active_addr_r;
    end
  end

  // =====================================================================
  // Checks.
  // =====================================================================
  // Voltages move only on an update strobe; bus writes never reach them.
  chk_volt_hold: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    !i_volt_update |=> $stable(volts_r))
    else $error("Voltage changed without an update.");

  // An update strobe lands the temperature voltage.
  chk_temp_latch: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    i_ce && i_volt_update |=> volts_r.temp == $past(i_volts.temp))
    else $error("Temperature voltage not latched.");

  // A clear pulse only follows a voltage read in auto mode.
  chk_conversion_done_flag_clear_src: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    o_conversion_done_flag_clear |-> ptr_volt && $past(i_auto_update))
    else $error("Conversion flag cleared by a wrong read.");

  // The compensation outputs carry the strobed voltages two cycles on.
  chk_comp_feed: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    i_ce && i_volt_update ##1 i_ce |=> o_volts == $past(i_volts, 2))
    else $error("Compensation path not fed the voltages.");

  // A completed write to the address register keeps the whole word.
  chk_addr_write: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    i_ce && addr_wr && !reload_r && !i_status_reset
    |=> addr_word_r == $past(commit_word))
    else $error("Address register write lost.");

  // Once loaded, the live address is never the invalid zero.
  chk_addr_valid: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    !reload_r |-> active_addr_r >= ADDR_MIN[6:0])
    else $error("Live address is invalid.");

  // The live address only moves during a reload.
  chk_addr_late: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    !reload_r && !i_status_reset |=> $stable(active_addr_r))
    else $error("Live address changed without a reset.");

  // The fit register packs the four orders high to low.
  chk_fit_layout: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    sel_fit |-> rd_word == {TT_ORDER, TP_ORDER, PT_ORDER, PP_ORDER})
    else $error("Fit order layout wrong.");

  // A word written to any other pointer leaves the address register.
  chk_ro_ignore: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    commit && !addr_wr && !reload_r |=> $stable(addr_word_r))
    else $error("Read-only write changed state.");

endmodule

// *** verif/i2c_host_model.sv ***
`timescale 1ns/100ps

// =====================================================================
// Bus master model
// =====================================================================
// Open-drain master. The clock stands high between frames, and each bit
// lasts 80 ns. A released line is pulled high by the bus pull-up.
module i2c_host_model (
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_pull
);
  // Both lines are released at rest.
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end

  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    #20 o_sda_pull = 1'b0;
    #20 o_scl = 1'b1;
    #20 o_sda_pull = 1'b1;
    #20 o_scl = 1'b0;
  endtask

  // Stop: data rises while the clock is high, then the bus rests.
  task automatic stop();
    #20 o_sda_pull = 1'b1;
    #20 o_scl = 1'b1;
    #20 o_sda_pull = 1'b0;
    #40;
  endtask

  // Send one byte MSB first, then sample the device acknowledge.
  task automatic send_byte(input logic [7:0] b, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      #20 o_sda_pull = ~b[i];
      #20 o_scl = 1'b1;
      #40 o_scl = 1'b0;
    end
    #20 o_sda_pull = 1'b0;
    #20 o_scl = 1'b1;
    #20 nak = i_sda;
    #20 o_scl = 1'b0;
  endtask

  // Receive one byte MSB first, then acknowledge or refuse it.
  task automatic recv_byte(input logic nak, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #20 o_sda_pull = 1'b0;
      #20 o_scl = 1'b1;
      #20 b[i] = i_sda;
      #20 o_scl = 1'b0;
    end
    #20 o_sda_pull = ~nak;
    #20 o_scl = 1'b1;
    #40 o_scl = 1'b0;
  endtask
endmodule

// *** verif/sensor_voltage_address_coef_regs_tb_top.sv ***
`timescale 1ns/100ps

// =====================================================================
// Testbench
// =====================================================================
module sensor_voltage_address_coef_regs_tb_top
  import xdcr_regs_pkg::*;
;
  localparam logic [31:0] VP = 32'h3F80_0000; // Pressure voltage.
  localparam logic [31:0] VT = 32'h4000_0000; // Temperature voltage.
  localparam logic [31:0] FIT = 32'h0102_0407; // Expected fit orders.
  typedef struct packed {
    logic [7:0] ptr;
    logic wr;
    logic [31:0] wd;
    logic [31:0] exp;
  } row_type;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic upd = 1'b0;
  logic auto = 1'b0;
  logic sreset = 1'b0;
  logic [31:0] nvm = 32'h0000_0002;
  element_volts_type volts = '0;
  logic scl, pull, sda_oe, sda_o, clr;
  element_volts_type ovolts;
  logic [31:0] addr_word, rd;
  logic [6:0] act;
  logic nak;
  int failures = 0;
  int n_compared = 0;
  int n_clr = 0;
  int cycles = 0;
  logic [7:0] v;
  logic [7:0] bad[5] = '{8'h00, 8'h80, 8'hFF, 8'h01, 8'h7F};
  row_type rows[7] = '{
    '{REG_PRESS_VOLT, 1'b0, 32'h0, VP},
    '{REG_TEMP_VOLT, 1'b0, 32'h0, VT},
    '{REG_FIT, 1'b0, 32'h0, FIT},
    '{REG_BUS_ADDR, 1'b1, 32'hABCD_EF12, 32'hABCD_EF12},
    '{REG_PRESS_VOLT, 1'b1, 32'h1234_5678, VP},
    '{REG_FIT, 1'b1, 32'hFFFF_FFFF, FIT},
    '{8'h10, 1'b0, 32'h0, 32'h0}};
  // Open-drain data line with pull-up.
  wire logic sda = ~(pull | sda_oe);

  always #2.5 i_mclk = ~i_mclk;

  xdcr_regs #(.TT_ORDER(8'h01), .TP_ORDER(8'h02), .PT_ORDER(8'h04),
      .PP_ORDER(8'h07)) u_xdcr_regs (.i_mclk(i_mclk), .i_srst(i_srst),
    .i_ce(1'b1), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o),
    .o_sda_oe(sda_oe), .i_volts(volts), .i_volt_update(upd),
    .i_auto_update(auto), .i_status_reset(sreset),
    .i_nvm_addr_word(nvm), .o_conversion_done_flag_clear(clr), .o_volts(ovolts),
    .o_addr_word(addr_word), .o_active_addr(act));

  i2c_host_model u_i2c_host_model (.i_sda(sda), .o_scl(scl),
    .o_sda_pull(pull));

  // Counts clear pulses and cuts a hang short.
  always @(posedge i_mclk) begin
    n_clr <= n_clr + int'(clr === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      $display("unexpected at %0t: run too long", $time);
      tally_and_finish();
    end
  end

  // Compares one value against its expectation.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask

  // One framed transfer; a refused address ends it at once.
  task automatic xfer(input logic [6:0] a, input logic [7:0] ptr,
      input logic wr, input logic [31:0] wd, output logic [31:0] r,
      output logic n);
    logic k;
    logic [7:0] b;
    r = 32'h0;
    u_i2c_host_model.start();
    u_i2c_host_model.send_byte({a, 1'b0}, n);
    if (n === 1'b0) begin
      u_i2c_host_model.send_byte(ptr, k);
      if (wr) begin
        for (int i = 3; i >= 0; i--) u_i2c_host_model.send_byte(wd[i*8+:8], k);
      end else begin
        u_i2c_host_model.start();
        u_i2c_host_model.send_byte({a, 1'b1}, k);
        for (int i = 3; i >= 0; i--) begin
          u_i2c_host_model.recv_byte(i == 0, b);
          r = {r[23:0], b};
        end
      end
    end
    u_i2c_host_model.stop();
  endtask

  // Pulses the status reset and lets the reload settle.
  task automatic status_reset();
    @(negedge i_mclk) sreset = 1'b1;
    @(negedge i_mclk) sreset = 1'b0;
    repeat (6) @(negedge i_mclk);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge i_mclk);
    i_srst = 1'b0;
    repeat (6) @(negedge i_mclk);
    check(addr_word, 32'h2, "reset word");
    check(32'(act), 32'h2, "reset addr");
    volts = '{press: VP, temp: VT};
    @(negedge i_mclk) upd = 1'b1;
    @(negedge i_mclk) upd = 1'b0;
    repeat (3) @(negedge i_mclk);
    check(ovolts.press, VP, "press volt");
    check(ovolts.temp, VT, "temp volt");
    $display("test volts done");
    // Ordinary register cases.
    foreach (rows[i]) begin
      if (rows[i].wr) xfer(7'h02, rows[i].ptr, 1'b1, rows[i].wd, rd, nak);
      xfer(7'h02, rows[i].ptr, 1'b0, 32'h0, rd, nak);
      check(rd, rows[i].exp, "row read");
    end
    check(32'(n_clr), 32'h0, "clear w/o auto");
    $display("test rows done");
    // Auto mode: only voltage reads clear the flag.
    auto = 1'b1;
    xfer(7'h02, REG_PRESS_VOLT, 1'b0, 32'h0, rd, nak);
    xfer(7'h02, REG_TEMP_VOLT, 1'b0, 32'h0, rd, nak);
    xfer(7'h02, REG_BUS_ADDR, 1'b0, 32'h0, rd, nak);
    check(32'(n_clr), 32'h2, "clear count");
    $display("test auto done");
    // New address waits for save and status reset.
    check(32'(act), 32'h2, "addr early");
    nvm = addr_word;
    status_reset();
    check(32'(act), 32'h12, "addr late");
    xfer(7'h02, REG_FIT, 1'b0, 32'h0, rd, nak);
    check(32'(nak), 32'h1, "old addr");
    xfer(7'h12, REG_FIT, 1'b0, 32'h0, rd, nak);
    check(rd, FIT, "new addr");
    $display("test address change done");
    // Invalid stored addresses fall back to the default.
    foreach (bad[i]) begin
      v = bad[i];
      nvm = {24'h0, v};
      status_reset();
      check(32'(act), (v >= ADDR_MIN && v <= ADDR_MAX) ? 32'(v) : 32'h2,
        "stored addr");
    end
    xfer(7'h7F, REG_TEMP_VOLT, 1'b0, 32'h0, rd, nak);
    check(rd, VT, "top addr");
    $display("test fallback done");
    // Mid-run reset: an invalid stored word reloads, address falls back.
    nvm = 32'h0000_0080;
    @(negedge i_mclk) i_srst = 1'b1;
    repeat (3) @(negedge i_mclk);
    i_srst = 1'b0;
    repeat (6) @(negedge i_mclk);
    check(addr_word, 32'h0000_0080, "srst word");
    check(32'(act), 32'h2, "srst addr");
    check(32'(sda_o), 32'h0, "sda value");
    xfer(7'h02, REG_PRESS_VOLT, 1'b0, 32'h0, rd, nak);
    check(rd, 32'h0, "srst volts");
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule
